// ===== hdl/sram_boundary_scan_tap.sv
// Functional notes
// - codes 000 and 010 capture pads, route boundary chain, force outputs high-Z.
// - code 001 loads fixed 32-bit identification and routes it out.
// - code 100 captures pads and routes boundary chain; no preload onto pads.
// - code 111 routes the one-bit bypass register; memory unaffected.
// - instruction 3 bits, bypass 1 bit, identification 32 bits.
// - wide variant chain holds 70 cells, address first, low address bits last.
// - identification bits 31:28 carry the revision number.
// - bits 27:23 give depth, 22:18 width, distinct per variant.
// - bits 17:12 are a reserved field.
// - bits 11:1 hold the maker code, same for both variants.
// - identification bit 0 always reads one.
// - serial output changes only after the test clock falls.
// - serial input and mode select sampled on test clock rise.
// - narrow variant chain holds 51 cells, low address bits last.
// - capture-IR loads 01 in low bits; new code acts at update-IR.
// - identification code selected at power-up and in test-logic-reset.
// - identification bit 0 leaves serial output first.
`include "sram_tap_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module sram_boundary_scan_tap #(
  parameter bit WIDE_VARIANT = 1'b1, // 1: x36 chain, 0: x18 chain
  parameter logic [3:0] ID_REVISION = 4'h0, // arbitrary value
  parameter logic [4:0] ID_DEPTH_WIDE = 5'h0a, // arbitrary value
  parameter logic [4:0] ID_DEPTH_NARROW = 5'h0b, // arbitrary value
  parameter logic [4:0] ID_WIDTH_WIDE = 5'h09, // arbitrary value
  parameter logic [4:0] ID_WIDTH_NARROW = 5'h0c, // arbitrary value
  parameter logic [5:0] ID_RESERVED = 6'h00, // arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h2a5 // arbitrary value
) (
  input wire logic clk_i, // system clock, 250 MHz
  input wire logic rst_n_i, // async reset, active low
  input wire logic tck_i, // test clock pin
  input wire logic tms_i, // test mode select pin
  input wire logic tdi_i, // test serial data in pin
  input wire logic [`TAP_BSR_LEN_X36-1:0] pad_state_i, // pad levels, bit n-1 is cell n
  output logic tdo_o, // test serial data out
  output logic tdo_oe_o, // high while tdo is driven
  output logic pad_hiz_o, // high forces device outputs high-Z
  output logic [`TAP_IR_LEN-1:0] instr_o // active instruction
);

  localparam int BSR_LEN = WIDE_VARIANT ? `TAP_BSR_LEN_X36 : `TAP_BSR_LEN_X18;
  localparam logic [4:0] ID_DEPTH = WIDE_VARIANT ? ID_DEPTH_WIDE : ID_DEPTH_NARROW;
  localparam logic [4:0] ID_WIDTH = WIDE_VARIANT ? ID_WIDTH_WIDE : ID_WIDTH_NARROW;

  // ----------------------------------------
  // instruction decode
  // ----------------------------------------
  function automatic logic sel_boundary(input logic [`TAP_IR_LEN-1:0] code);
    sel_boundary = (code == `TAP_IR_EXTEST) || (code == `TAP_IR_SAMPLE_Z) ||
                   (code == `TAP_IR_SAMPLE);
  endfunction : sel_boundary

  function automatic logic sel_ident(input logic [`TAP_IR_LEN-1:0] code);
    sel_ident = (code == `TAP_IR_IDCODE);
  endfunction : sel_ident

  function automatic logic forces_hiz(input logic [`TAP_IR_LEN-1:0] code);
    forces_hiz = (code == `TAP_IR_EXTEST) || (code == `TAP_IR_SAMPLE_Z);
  endfunction : forces_hiz

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // test clock is sampled, not used as a clock; tms/tdi share its delay
  sram_tap_pkg::tap_pins_t pins_s1_reg;
  sram_tap_pkg::tap_pins_t pins_s2_reg;
  sram_tap_pkg::tap_pins_t pins_s1_next;
  sram_tap_pkg::tap_pins_t pins_s2_next;
  logic tck_prev_reg;
  logic tck_prev_next;
  // narrow variant leaves the upper pad bits unread
  logic [`TAP_BSR_LEN_X36-1:0] pad_s1_reg;
  logic [`TAP_BSR_LEN_X36-1:0] pad_s2_reg;
  logic [`TAP_BSR_LEN_X36-1:0] pad_s1_next;
  logic [`TAP_BSR_LEN_X36-1:0] pad_s2_next;

  always_comb begin
    pins_s1_next = '{tck: tck_i, tms: tms_i, tdi: tdi_i};
    pins_s2_next = pins_s1_reg;
    tck_prev_next = pins_s2_reg.tck;
    pad_s1_next = pad_state_i;
    pad_s2_next = pad_s1_reg;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_s1_reg <= '0;
      pins_s2_reg <= '0;
      tck_prev_reg <= 1'h0;
      pad_s1_reg <= '0;
      pad_s2_reg <= '0;
    end else begin
      pins_s1_reg <= pins_s1_next;
      pins_s2_reg <= pins_s2_next;
      tck_prev_reg <= tck_prev_next;
      pad_s1_reg <= pad_s1_next;
      pad_s2_reg <= pad_s2_next;
    end
  end

  logic tck_rise;
  logic tck_fall;
  assign tck_rise = pins_s2_reg.tck & ~tck_prev_reg;
  assign tck_fall = ~pins_s2_reg.tck & tck_prev_reg;

  // ----------------------------------------
  // controller
  // ----------------------------------------
  sram_tap_pkg::tap_state_t state;

  tap_state_machine u_fsm (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .step_i(tck_rise),
    .tms_i(pins_s2_reg.tms),
    .state_o(state)
  );

  logic in_cap_dr;
  logic in_shift_dr;
  logic in_cap_ir;
  logic in_shift_ir;
  assign in_cap_dr = (state == sram_tap_pkg::st_cap_dr);
  assign in_shift_dr = (state == sram_tap_pkg::st_shift_dr);
  assign in_cap_ir = (state == sram_tap_pkg::st_cap_ir);
  assign in_shift_ir = (state == sram_tap_pkg::st_shift_ir);

  // ----------------------------------------
  // data register strobes
  // ----------------------------------------
  // one strobe per detected rise, shared by every data register
  logic cap_dr_step;
  logic shift_dr_step;
  assign cap_dr_step = tck_rise && in_cap_dr;
  assign shift_dr_step = tck_rise && in_shift_dr;

  // ----------------------------------------
  // instruction register
  // ----------------------------------------
  logic [`TAP_IR_LEN-1:0] ir_shift_reg;
  logic [`TAP_IR_LEN-1:0] ir_shift_next;
  logic [`TAP_IR_LEN-1:0] ir_reg;
  logic [`TAP_IR_LEN-1:0] ir_next;

  always_comb begin
    ir_shift_next = ir_shift_reg;
    ir_next = ir_reg;
    if (tck_rise && in_cap_ir) begin
      ir_shift_next = `TAP_IR_CAPTURE_VAL;
    end else if (tck_rise && in_shift_ir) begin
      ir_shift_next = {pins_s2_reg.tdi, ir_shift_reg[`TAP_IR_LEN-1:1]};
    end
    if (state == sram_tap_pkg::st_reset) begin
      ir_next = `TAP_IR_IDCODE;
    end else if (tck_fall && state == sram_tap_pkg::st_upd_ir) begin
      ir_next = ir_shift_reg;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ir_shift_reg <= `TAP_IR_CAPTURE_VAL;
      ir_reg <= `TAP_IR_IDCODE;
    end else begin
      ir_shift_reg <= ir_shift_next;
      ir_reg <= ir_next;
    end
  end

  logic use_bsr;
  logic use_id;
  logic use_bypass;
  assign use_bsr = sel_boundary(ir_reg);
  assign use_id = sel_ident(ir_reg);
  // reserved codes fall onto bypass so the scan path never breaks
  assign use_bypass = !use_bsr && !use_id;

  // ----------------------------------------
  // bypass register
  // ----------------------------------------
  logic bypass_reg;
  logic bypass_next;

  always_comb begin
    bypass_next = bypass_reg;
    if (cap_dr_step && use_bypass) begin
      bypass_next = `TAP_BYPASS_CAPTURE_VAL;
    end else if (shift_dr_step && use_bypass) begin
      bypass_next = pins_s2_reg.tdi;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bypass_reg <= `TAP_BYPASS_CAPTURE_VAL;
    end else begin
      bypass_reg <= bypass_next;
    end
  end

  // ----------------------------------------
  // identification register
  // ----------------------------------------
  logic [`TAP_ID_LEN-1:0] id_value;
  always_comb begin
    id_value = '0;
    id_value[`TAP_ID_REV_MSB:`TAP_ID_REV_LSB] = ID_REVISION;
    id_value[`TAP_ID_DEPTH_MSB:`TAP_ID_DEPTH_LSB] = ID_DEPTH;
    id_value[`TAP_ID_WIDTH_MSB:`TAP_ID_WIDTH_LSB] = ID_WIDTH;
    id_value[`TAP_ID_RSVD_MSB:`TAP_ID_RSVD_LSB] = ID_RESERVED;
    id_value[`TAP_ID_MFR_MSB:`TAP_ID_MFR_LSB] = ID_MAKER;
    id_value[`TAP_ID_PRESENT_BIT] = `TAP_ID_PRESENT_VAL;
  end

  logic id_serial;
  // lsb sits at the output end, so bit 0 leaves first
  scan_shift_reg #(
    .LEN(`TAP_ID_LEN)
  ) u_id_chain (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .capture_i(cap_dr_step && use_id),
    .shift_i(shift_dr_step && use_id),
    .serial_i(pins_s2_reg.tdi),
    .load_i(id_value),
    .serial_o(id_serial)
  );

  // ----------------------------------------
  // boundary scan chain
  // ----------------------------------------
  // capture only; no update stage, so nothing is ever driven onto pads
  logic bsr_serial;
  scan_shift_reg #(
    .LEN(BSR_LEN)
  ) u_bsr_chain (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .capture_i(cap_dr_step && use_bsr),
    .shift_i(shift_dr_step && use_bsr),
    .serial_i(pins_s2_reg.tdi),
    .load_i(pad_s2_reg[BSR_LEN-1:0]),
    .serial_o(bsr_serial)
  );

  // ----------------------------------------
  // serial output and pad control
  // ----------------------------------------
  logic tdo_reg;
  logic tdo_next;
  logic tdo_oe_reg;
  logic tdo_oe_next;
  logic pad_hiz_reg;
  logic pad_hiz_next;
  logic dr_serial;

  always_comb begin
    dr_serial = bypass_reg;
    if (use_bsr) begin
      dr_serial = bsr_serial;
    end else if (use_id) begin
      dr_serial = id_serial;
    end
  end

  // instruction shift starts with the captured 01 pattern
  always_comb begin
    tdo_next = tdo_reg;
    tdo_oe_next = tdo_oe_reg;
    if (tck_fall) begin
      tdo_oe_next = in_shift_dr || in_shift_ir;
      if (in_shift_ir) begin
        tdo_next = ir_shift_reg[0];
      end else if (in_shift_dr) begin
        tdo_next = dr_serial;
      end
    end
    pad_hiz_next = forces_hiz(ir_reg);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tdo_reg <= `TAP_TDO_RESET_VAL;
      tdo_oe_reg <= 1'h0;
      pad_hiz_reg <= 1'h0;
    end else begin
      tdo_reg <= tdo_next;
      tdo_oe_reg <= tdo_oe_next;
      pad_hiz_reg <= pad_hiz_next;
    end
  end

  assign tdo_o = tdo_reg;
  assign tdo_oe_o = tdo_oe_reg;
  assign pad_hiz_o = pad_hiz_reg;
  assign instr_o = ir_reg;

endmodule : sram_boundary_scan_tap
`default_nettype wire

// ===== hdl/sram_tap_regs.svh
`ifndef SRAM_TAP_REGS_SVH
`define SRAM_TAP_REGS_SVH

// ----------------------------------------
// scan register sizes
// ----------------------------------------
`define TAP_IR_LEN 3
`define TAP_BYPASS_LEN 1
`define TAP_ID_LEN 32
`define TAP_BSR_LEN_X36 70
`define TAP_BSR_LEN_X18 51

// ----------------------------------------
// instruction codes
// ----------------------------------------
`define TAP_IR_EXTEST 3'h0
`define TAP_IR_IDCODE 3'h1
`define TAP_IR_SAMPLE_Z 3'h2
`define TAP_IR_RSVD_3 3'h3
`define TAP_IR_SAMPLE 3'h4
`define TAP_IR_RSVD_5 3'h5
`define TAP_IR_RSVD_6 3'h6
`define TAP_IR_BYPASS 3'h7
`define TAP_IR_CAPTURE_VAL 3'h1

// ----------------------------------------
// identification field layout
// ----------------------------------------
`define TAP_ID_REV_MSB 31
`define TAP_ID_REV_LSB 28
`define TAP_ID_DEPTH_MSB 27
`define TAP_ID_DEPTH_LSB 23
`define TAP_ID_WIDTH_MSB 22
`define TAP_ID_WIDTH_LSB 18
`define TAP_ID_RSVD_MSB 17
`define TAP_ID_RSVD_LSB 12
`define TAP_ID_MFR_MSB 11
`define TAP_ID_MFR_LSB 1
`define TAP_ID_PRESENT_BIT 0
`define TAP_ID_PRESENT_VAL 1'h1

// ----------------------------------------
// reset values
// ----------------------------------------
`define TAP_BYPASS_CAPTURE_VAL 1'h0
`define TAP_TDO_RESET_VAL 1'h0

`endif

// ===== hdl/sram_tap_pkg.sv
package sram_tap_pkg;

  // ----------------------------------------
  // controller states, one-hot
  // ----------------------------------------
  typedef enum logic [15:0] {
    st_reset    = 16'h0001,
    st_idle     = 16'h0002,
    st_sel_dr   = 16'h0004,
    st_cap_dr   = 16'h0008,
    st_shift_dr = 16'h0010,
    st_exit1_dr = 16'h0020,
    st_pause_dr = 16'h0040,
    st_exit2_dr = 16'h0080,
    st_upd_dr   = 16'h0100,
    st_sel_ir   = 16'h0200,
    st_cap_ir   = 16'h0400,
    st_shift_ir = 16'h0800,
    st_exit1_ir = 16'h1000,
    st_pause_ir = 16'h2000,
    st_exit2_ir = 16'h4000,
    st_upd_ir   = 16'h8000
  } tap_state_t;

  // ----------------------------------------
  // serial pins after synchronisation
  // ----------------------------------------
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tap_pins_t;

endpackage : sram_tap_pkg

// ===== hdl/tap_state_machine.sv
`timescale 1ns/10ps
`default_nettype none
module tap_state_machine (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic step_i, // one-cycle pulse per test clock rise
  input wire logic tms_i, // mode select sampled with step_i
  output sram_tap_pkg::tap_state_t state_o // current state
);

  sram_tap_pkg::tap_state_t state_reg;
  sram_tap_pkg::tap_state_t state_next;

  // ----------------------------------------
  // sixteen-state controller
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    if (step_i) begin
      case (state_reg)
        sram_tap_pkg::st_reset: state_next = tms_i ? sram_tap_pkg::st_reset : sram_tap_pkg::st_idle;
        sram_tap_pkg::st_idle: state_next = tms_i ? sram_tap_pkg::st_sel_dr : sram_tap_pkg::st_idle;
        sram_tap_pkg::st_sel_dr: state_next = tms_i ? sram_tap_pkg::st_sel_ir : sram_tap_pkg::st_cap_dr;
        sram_tap_pkg::st_cap_dr: state_next = tms_i ? sram_tap_pkg::st_exit1_dr : sram_tap_pkg::st_shift_dr;
        sram_tap_pkg::st_shift_dr: state_next = tms_i ? sram_tap_pkg::st_exit1_dr : sram_tap_pkg::st_shift_dr;
        sram_tap_pkg::st_exit1_dr: state_next = tms_i ? sram_tap_pkg::st_upd_dr : sram_tap_pkg::st_pause_dr;
        sram_tap_pkg::st_pause_dr: state_next = tms_i ? sram_tap_pkg::st_exit2_dr : sram_tap_pkg::st_pause_dr;
        sram_tap_pkg::st_exit2_dr: state_next = tms_i ? sram_tap_pkg::st_upd_dr : sram_tap_pkg::st_shift_dr;
        sram_tap_pkg::st_upd_dr: state_next = tms_i ? sram_tap_pkg::st_sel_dr : sram_tap_pkg::st_idle;
        sram_tap_pkg::st_sel_ir: state_next = tms_i ? sram_tap_pkg::st_reset : sram_tap_pkg::st_cap_ir;
        sram_tap_pkg::st_cap_ir: state_next = tms_i ? sram_tap_pkg::st_exit1_ir : sram_tap_pkg::st_shift_ir;
        sram_tap_pkg::st_shift_ir: state_next = tms_i ? sram_tap_pkg::st_exit1_ir : sram_tap_pkg::st_shift_ir;
        sram_tap_pkg::st_exit1_ir: state_next = tms_i ? sram_tap_pkg::st_upd_ir : sram_tap_pkg::st_pause_ir;
        sram_tap_pkg::st_pause_ir: state_next = tms_i ? sram_tap_pkg::st_exit2_ir : sram_tap_pkg::st_pause_ir;
        sram_tap_pkg::st_exit2_ir: state_next = tms_i ? sram_tap_pkg::st_upd_ir : sram_tap_pkg::st_shift_ir;
        sram_tap_pkg::st_upd_ir: state_next = tms_i ? sram_tap_pkg::st_sel_dr : sram_tap_pkg::st_idle;
        // illegal code falls back to reset state
        default: state_next = sram_tap_pkg::st_reset;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= sram_tap_pkg::st_reset;
    end else begin
      state_reg <= state_next;
    end
  end

  assign state_o = state_reg;

endmodule : tap_state_machine
`default_nettype wire

// ===== hdl/scan_shift_reg.sv
`timescale 1ns/10ps
`default_nettype none
module scan_shift_reg #(
  parameter int LEN = 32
) (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic capture_i, // parallel load pulse
  input wire logic shift_i, // shift one bit toward lsb
  input wire logic serial_i, // bit entering at msb
  input wire logic [LEN-1:0] load_i, // parallel capture value
  output logic serial_o // lsb, next bit out
);

  logic [LEN-1:0] chain_reg;
  logic [LEN-1:0] chain_next;

  // ----------------------------------------
  // capture and shift
  // ----------------------------------------
  always_comb begin
    chain_next = chain_reg;
    if (capture_i) begin
      chain_next = load_i;
    end else if (shift_i) begin
      chain_next = {serial_i, chain_reg[LEN-1:1]};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= chain_next;
    end
  end

  assign serial_o = chain_reg[0];

endmodule : scan_shift_reg
`default_nettype wire

// ===== tb/sram_boundary_scan_tap_props.sv
`timescale 1ns/10ps
`default_nettype none
module sram_boundary_scan_tap_props (
  input wire logic clk_i, // system clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic tck_i, // test clock pin
  input wire logic tms_i, // mode select pin
  input wire logic tdi_i, // serial in pin
  input wire logic [69:0] pad_state_i, // pad levels
  input wire logic tdo_o, // serial out
  input wire logic tdo_oe_o, // serial out enable
  input wire logic pad_hiz_o, // outputs forced high-Z
  input wire logic [2:0] instr_o // active instruction
);
  // ----------------------------------------
  // helper: own view of test clock rises
  // ----------------------------------------
  logic [2:0] tck_sync_reg, tck_sync_next;
  logic [2:0] ones_reg, ones_next;
  logic tck_rise;

  always_comb begin
    tck_sync_next = {tck_sync_reg[1:0], tck_i};
    tck_rise = tck_sync_reg[1] & ~tck_sync_reg[2];
    ones_next = ones_reg;
    if (tck_rise) begin
      // saturates: five ones is enough to reach test-logic-reset
      ones_next = !tms_i ? 3'h0 : (ones_reg == 3'h5) ? ones_reg : ones_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tck_sync_reg <= 3'h0;
      ones_reg <= 3'h0;
    end else begin
      tck_sync_reg <= tck_sync_next;
      ones_reg <= ones_next;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  reset_vals_a: assert property ($rose(rst_n_i) |-> instr_o == 3'h1 && !tdo_oe_o && !pad_hiz_o)
    else $error("state after reset release is wrong");
  tms_reset_a: assert property (ones_reg == 3'h5 |-> ##8 instr_o == 3'h1)
    else $error("five mode-select ones did not select identification");
  hiz_follow_a: assert property (pad_hiz_o == ($past(instr_o) inside {3'h0, 3'h2}))
    else $error("high-Z control does not match instruction");
  tdo_edge_a: assert property ($changed(tdo_o) |-> !$past(tck_i) && !$past(tck_i, 2))
    else $error("serial out moved while test clock high");
  oe_edge_a: assert property ($changed(tdo_oe_o) |-> !$past(tck_i))
    else $error("serial enable moved while test clock high");
  oe_after_rise_a: assert property ($rose(tdo_oe_o) |-> $past(tck_i, 5))
    else $error("shifting began without a preceding clock rise");
  tdo_hold_a: assert property ($rose(tdo_oe_o) |-> ##2 $stable(tdo_o) [*6])
    else $error("serial out not held through low phase");
  id_first_a: assert property ($rose(tdo_oe_o) && instr_o == 3'h1 |-> tdo_o)
    else $error("first bit out under identification is not one");
  instr_edge_a: assert property (
    $changed(instr_o) && instr_o != 3'h1 |-> !$past(tck_i) && !$past(tck_i, 2))
    else $error("instruction changed outside a clock fall");
endmodule : sram_boundary_scan_tap_props

bind sram_boundary_scan_tap sram_boundary_scan_tap_props sram_boundary_scan_tap_props_i (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .tck_i(tck_i),
  .tms_i(tms_i),
  .tdi_i(tdi_i),
  .pad_state_i(pad_state_i),
  .tdo_o(tdo_o),
  .tdo_oe_o(tdo_oe_o),
  .pad_hiz_o(pad_hiz_o),
  .instr_o(instr_o)
);
`default_nettype wire

// ===== tb/scan_controller_model.sv
`timescale 1ns/10ps
`default_nettype none
module scan_controller_model (
  output logic tck_o, // test clock, idles low between frames
  output logic tms_o, // mode select
  output logic tdi_o, // serial data toward device
  input wire logic tdo_i // serial data from device
);
  localparam realtime half_period = 62.5;

  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // pins move in the low phase so they are long settled at the rise
  // nba: a pin edge landing on a clk edge must not race the samplers
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o <= tms;
    tdi_o <= tdi;
    #(half_period);
    tck_o <= 1'b1;
    tdo = tdo_i;
    #(half_period);
    tck_o <= 1'b0;
  endtask : step

  task automatic reset_fsm;
    logic b;
    repeat (5) step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask : reset_fsm

  task automatic shift_ir(input logic [2:0] code, output logic [2:0] cap);
    logic b;
    step(1'b1, 1'b0, b);
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int k = 0; k < 3; k++) begin
      step(logic'(k == 2), code[k], b);
      cap[k] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask : shift_ir

  task automatic shift_dr(input int n, input logic [69:0] din, output logic [69:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
    step(1'b0, 1'b0, b);
    for (int k = 0; k < n; k++) begin
      step(logic'(k == n - 1), din[k], b);
      dout[k] = b;
    end
    step(1'b1, 1'b0, b);
    step(1'b0, 1'b0, b);
  endtask : shift_dr
endmodule : scan_controller_model
`default_nettype wire

// ===== tb/sram_boundary_scan_tap_test.sv
`timescale 1ns/10ps
`default_nettype none
module sram_boundary_scan_tap_test;
  // ----------------------------------------
  // identification fields, arbitrary values
  // ----------------------------------------
  localparam logic [3:0] rev = 4'h3;
  localparam logic [4:0] depth_w = 5'h15;
  localparam logic [4:0] depth_n = 5'h16;
  localparam logic [4:0] width_w = 5'h0d;
  localparam logic [4:0] width_n = 5'h0e;
  localparam logic [5:0] rsvd = 6'h2a;
  localparam logic [10:0] maker = 11'h4b6;
  localparam logic [31:0] id_w = {rev, depth_w, width_w, rsvd, maker, 1'b1};
  localparam logic [31:0] id_n = {rev, depth_n, width_n, rsvd, maker, 1'b1};
  localparam logic [69:0] din = 70'h1a_dead_beef_0bad_f00d;
  localparam int limit = 40000;
  localparam logic [10:0] tms_walk = 11'b01101000011;
  localparam logic [10:0] tdi_walk = 11'h020;

  typedef struct packed {
    logic [2:0] code;
    logic hiz;
    logic [1:0] path;
  } row_t;
  // reserved codes 3, 5 and 6 are left out of this table
  localparam row_t rows [5] = '{'{3'h0, 1'b1, 2'h0}, '{3'h1, 1'b0, 2'h1},
    '{3'h2, 1'b1, 2'h0}, '{3'h4, 1'b0, 2'h0}, '{3'h7, 1'b0, 2'h2}};

  logic clk_i;
  logic rst_n_i;
  logic [69:0] pads;
  wire [1:0] tck;
  wire [1:0] tms;
  wire [1:0] tdi;
  wire [1:0] tdo_pin;
  logic [1:0] tdo_raw;
  logic [1:0] tdo_oe;
  logic [1:0] hiz;
  logic [5:0] instr;
  int n_checks = 0;
  int miscompares = 0;
  int cycles = 0;

  always #2 clk_i = ~clk_i;

  // lane 0 is the wide variant, lane 1 the narrow one
  for (genvar g = 0; g < 2; g++) begin : lane
    assign tdo_pin[g] = tdo_oe[g] ? tdo_raw[g] : 1'bz;
    sram_boundary_scan_tap #(
      .WIDE_VARIANT(g == 0), .ID_REVISION(rev), .ID_DEPTH_WIDE(depth_w),
      .ID_DEPTH_NARROW(depth_n), .ID_WIDTH_WIDE(width_w), .ID_WIDTH_NARROW(width_n),
      .ID_RESERVED(rsvd), .ID_MAKER(maker)
    ) sram_boundary_scan_tap_i (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .tck_i(tck[g]), .tms_i(tms[g]), .tdi_i(tdi[g]),
      .pad_state_i(pads), .tdo_o(tdo_raw[g]), .tdo_oe_o(tdo_oe[g]), .pad_hiz_o(hiz[g]),
      .instr_o(instr[g*3 +: 3])
    );
    scan_controller_model scan_controller_model_i (
      .tck_o(tck[g]), .tms_o(tms[g]), .tdi_o(tdi[g]), .tdo_i(tdo_pin[g])
    );
  end

  // ----------------------------------------
  // comparison and closing
  // ----------------------------------------
  task automatic check(input logic [69:0] seen, input logic [69:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == limit) begin
      miscompares++;
      end_sim();
    end
  end

  initial begin
    logic [2:0] cap;
    logic [69:0] dout;
    logic b;
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    pads = '0;
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    // controller wakes in test-logic-reset; walk it to idle first
    lane[0].scan_controller_model_i.reset_fsm();
    for (int r = 0; r < 5; r++) begin
      @(negedge clk_i);
      pads = 70'h2f_0123_4567_89ab_cdef ^ (70'(r) * 70'h10_1010_1010_1010_1011);
      lane[0].scan_controller_model_i.shift_ir(rows[r].code, cap);
      check(70'(cap), 70'h1);
      check(70'(instr[2:0]), 70'(rows[r].code));
      check(70'(hiz[0]), 70'(rows[r].hiz));
      lane[0].scan_controller_model_i.shift_dr(70, din, dout);
      case (rows[r].path)
        2'h0: check(dout, pads);
        2'h1: check(dout, {din[37:0], id_w});
        default: check(dout, {din[68:0], 1'b0});
      endcase
    end
    // new code held back through pause until update
    for (int k = 0; k < 11; k++) begin
      lane[0].scan_controller_model_i.step(tms_walk[k], tdi_walk[k], b);
      if (k == 8) check(70'(instr[2:0]), 70'h7);
    end
    check(70'(instr[2:0]), 70'h2);
    check(70'(hiz[0]), 70'h1);
    lane[0].scan_controller_model_i.reset_fsm();
    check(70'(instr[2:0]), 70'h1);
    check(70'(hiz[0]), 70'h0);
    lane[0].scan_controller_model_i.shift_dr(32, din, dout);
    check(dout, {38'h0, id_w});
    // reset in mid-run with a high-Z instruction active
    lane[0].scan_controller_model_i.shift_ir(3'h0, cap);
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check(70'(instr[2:0]), 70'h1);
    check(70'(hiz[0]), 70'h0);
    lane[0].scan_controller_model_i.reset_fsm();
    lane[1].scan_controller_model_i.reset_fsm();
    lane[1].scan_controller_model_i.shift_dr(32, din, dout);
    check(dout, {38'h0, id_n});
    lane[1].scan_controller_model_i.shift_ir(3'h0, cap);
    lane[1].scan_controller_model_i.shift_dr(53, din, dout);
    check(dout, {17'h0, din[1:0], pads[50:0]});
    end_sim();
  end
endmodule : sram_boundary_scan_tap_test
`default_nettype wire
